// [inc/clb_pkg.sv]
package clb_pkg;

  // Bus operation kinds
  typedef enum logic [2:0] {
    CLB_OP_MEM_RD,
    CLB_OP_MEM_WR,
    CLB_OP_IO_RD,
    CLB_OP_IO_WR,
    CLB_OP_INTA,
    CLB_OP_HALT
  } clb_op_t;

  // Local bus states
  typedef enum logic [1:0] {
    CLB_ST_IDLE,
    CLB_ST_STATUS,
    CLB_ST_COMMAND,
    CLB_ST_HOLD
  } clb_state_t;

  // Request from the core side
  typedef struct packed {
    clb_op_t op;
    logic is_word;
    logic [23:0] addr;
    logic [15:0] wdata;
  } clb_req_t;

  // Lane steering result for one bus piece
  typedef struct packed {
    logic addr_lsb;
    logic ube_n;
    logic split;
    logic take_lo;
    logic take_hi;
    logic [15:0] wbus;
    logic [7:0] rd_lo;
    logic [7:0] rd_hi;
  } clb_lane_t;

  // Status code bits: {mem_io, code_inta, status_line_1, status_line_0}
  localparam logic [3:0] CLB_STAT_IDLE = 4'hf;
  localparam logic [3:0] CLB_STAT_MEM_RD = 4'hd;
  localparam logic [3:0] CLB_STAT_MEM_WR = 4'he;
  localparam logic [3:0] CLB_STAT_IO_RD = 4'h5;
  localparam logic [3:0] CLB_STAT_IO_WR = 4'h6;
  localparam logic [3:0] CLB_STAT_INTA = 4'h0;
  localparam logic [3:0] CLB_STAT_HALT = 4'h8;

  // Address space masks and address step
  localparam logic [23:0] CLB_MASK_FULL = 24'hffffff;
  localparam logic [23:0] CLB_MASK_REAL = 24'h0fffff;
  localparam logic [23:0] CLB_MASK_IO = 24'h00ffff;
  localparam logic [23:0] CLB_ADDR_STEP = 24'h000001;

  // Values after reset
  localparam logic [23:0] CLB_ADDR_RST = 24'h000000;
  localparam logic [15:0] CLB_DATA_RST = 16'h0000;
  localparam logic CLB_PHASE2_RST = 1'b0;

  // Status encoding per operation
  function automatic logic [3:0] clb_status_code(input clb_op_t op);
    logic [3:0] code;
    code = CLB_STAT_IDLE;
    case (op)
      CLB_OP_MEM_RD: code = CLB_STAT_MEM_RD;
      CLB_OP_MEM_WR: code = CLB_STAT_MEM_WR;
      CLB_OP_IO_RD: code = CLB_STAT_IO_RD;
      CLB_OP_IO_WR: code = CLB_STAT_IO_WR;
      CLB_OP_INTA: code = CLB_STAT_INTA;
      CLB_OP_HALT: code = CLB_STAT_HALT;
      default: code = CLB_STAT_IDLE;
    endcase
    return code;
  endfunction

endpackage

// [core/clb_lane_steer.sv]
module clb_lane_steer
  import clb_pkg::*;
(
  input wire logic is_word_in,
  input wire logic addr0_in,
  input wire logic step2_in,
  input wire logic [15:0] wdata_in,
  input wire logic [15:0] rbus_in,
  output clb_lane_t lane_out
);

  // Piece classification
  wire odd_piece = addr0_in & ~step2_in;
  wire split = is_word_in & addr0_in;
  wire full_word = is_word_in & ~addr0_in;
  wire second = split & step2_in;

  // Byte placement: low byte of a word belongs to the lower address
  wire [15:0] wbus = full_word ? wdata_in :
                     second ? {wdata_in[15:8], wdata_in[15:8]} :
                     {wdata_in[7:0], wdata_in[7:0]};
  wire [7:0] rd_lo = odd_piece ? rbus_in[15:8] : rbus_in[7:0];
  wire [7:0] rd_hi = full_word ? rbus_in[15:8] : rbus_in[7:0];

  // Lane select pins and read merge enables
  assign lane_out = '{
    addr_lsb: odd_piece,
    ube_n: ~(odd_piece | full_word),
    split: split,
    take_lo: ~second,
    take_hi: full_word | second,
    wbus: wbus,
    rd_lo: rd_lo,
    rd_hi: rd_hi
  };

endmodule

// [core/clb_bus_unit.sv]
module clb_bus_unit
  import clb_pkg::*;
(
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic ce_in,
  input wire logic real_mode_in,
  input wire logic req_valid_in,
  output logic req_ready_out,
  input wire clb_req_t req_in,
  output logic rsp_valid_out,
  output logic [15:0] rsp_rdata_out,
  input wire logic ready_n_in,
  input wire logic bus_request_in,
  input wire logic phase_next_p1_in,
  input wire logic [15:0] data_in,
  output logic [15:0] data_out,
  output logic data_oe_out,
  output logic [23:1] addr_out,
  output logic address_lsb_out,
  output logic upper_byte_enable_n_out,
  output logic status_line_1_out,
  output logic status_line_0_out,
  output logic mem_io_out,
  output logic code_inta_out,
  output logic addr_oe_out,
  output logic bus_grant_ack_out
);

  clb_state_t state_ff;
  clb_state_t nxt_state;
  logic phase2_ff;
  logic ready_seen_ff;
  logic step2_ff;
  clb_req_t op_ff;
  logic hold_s1_ff;
  logic hold_s2_ff;
  logic [23:0] addr_ff;
  logic ube_n_ff;
  logic [3:0] status_ff;
  logic addr_oe_ff;
  logic grant_ff;
  logic [15:0] data_ff;
  logic data_oe_ff;
  logic [15:0] rdata_ff;
  logic rsp_valid_ff;
  logic real_ff;
  clb_lane_t lane_ld;
  clb_lane_t lane_cur;

  // State and phase decode
  wire in_ti = (state_ff == CLB_ST_IDLE);
  wire in_ts = (state_ff == CLB_ST_STATUS);
  wire in_tc = (state_ff == CLB_ST_COMMAND);
  wire in_th = (state_ff == CLB_ST_HOLD);
  wire p1_end = ce_in & ~phase2_ff;
  wire pclk_end = ce_in & phase2_ff;
  wire hold_req = hold_s2_ff;

  // Operation progress decode
  wire piece_done = in_tc & ready_seen_ff;
  wire need_split = lane_cur.split & ~step2_ff;
  wire op_done = piece_done & ~need_split;
  wire cur_write = (op_ff.op == CLB_OP_MEM_WR) | (op_ff.op == CLB_OP_IO_WR);
  wire cur_read = (op_ff.op == CLB_OP_MEM_RD) | (op_ff.op == CLB_OP_IO_RD) | (op_ff.op == CLB_OP_INTA);
  wire bus_free = in_ti | op_done;

  // Request acceptance: only at a processor clock boundary with the bus free
  assign req_ready_out = pclk_end & bus_free & ~hold_req;
  wire take = req_valid_in & req_ready_out;

  // Address space limits per operation kind
  wire req_io = (req_in.op == CLB_OP_IO_RD) | (req_in.op == CLB_OP_IO_WR);
  wire op_io = (op_ff.op == CLB_OP_IO_RD) | (op_ff.op == CLB_OP_IO_WR);
  wire [23:0] req_mask = req_io ? CLB_MASK_IO : (real_mode_in ? CLB_MASK_REAL : CLB_MASK_FULL);
  wire [23:0] op_mask = op_io ? CLB_MASK_IO : (real_ff ? CLB_MASK_REAL : CLB_MASK_FULL);
  wire [23:0] req_addr_m = req_in.addr & req_mask;
  wire [23:0] next_byte_addr = (op_ff.addr + CLB_ADDR_STEP) & op_mask;

  // Piece that is loaded onto the pins at this boundary
  wire ld_word = take ? req_in.is_word : op_ff.is_word;
  wire ld_a0 = take ? req_addr_m[0] : op_ff.addr[0];
  wire ld_step2 = ~take;
  wire [23:0] ld_addr = take ? req_addr_m : next_byte_addr;
  wire [3:0] ld_status = clb_status_code(take ? req_in.op : op_ff.op);
  wire load_piece = pclk_end & (take | (piece_done & need_split));

  // Lane steering for the piece being loaded
  clb_lane_steer u_lane_ld (
    .is_word_in(ld_word),
    .addr0_in(ld_a0),
    .step2_in(ld_step2),
    .wdata_in(CLB_DATA_RST),
    .rbus_in(CLB_DATA_RST),
    .lane_out(lane_ld)
  );

  // Lane steering for the piece now on the bus
  clb_lane_steer u_lane_cur (
    .is_word_in(op_ff.is_word),
    .addr0_in(op_ff.addr[0]),
    .step2_in(step2_ff),
    .wdata_in(op_ff.wdata),
    .rbus_in(data_in),
    .lane_out(lane_cur)
  );

  // Bus state sequencing, evaluated once per processor clock
  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      CLB_ST_IDLE: nxt_state = take ? CLB_ST_STATUS : (hold_req ? CLB_ST_HOLD : CLB_ST_IDLE);
      CLB_ST_STATUS: nxt_state = CLB_ST_COMMAND;
      CLB_ST_COMMAND:
      begin
        if (!ready_seen_ff)
          nxt_state = CLB_ST_COMMAND;
        else if (need_split || take)
          nxt_state = CLB_ST_STATUS;
        else if (hold_req)
          nxt_state = cur_write ? CLB_ST_IDLE : CLB_ST_HOLD;
        else
          nxt_state = CLB_ST_IDLE;
      end
      CLB_ST_HOLD: nxt_state = hold_req ? CLB_ST_HOLD : CLB_ST_IDLE;
      default: nxt_state = CLB_ST_IDLE;
    endcase
  end

  // Processor clock phase: halves the system clock, realigned while the bus rests
  wire nxt_phase2 = (in_ti | in_th) ? ~phase_next_p1_in : ~phase2_ff;

  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      phase2_ff <= CLB_PHASE2_RST;
    else if (ce_in)
      phase2_ff <= nxt_phase2;
  end

  // Bus state register
  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      state_ff <= CLB_ST_IDLE;
    else if (pclk_end)
      state_ff <= nxt_state;
  end

  // Bus request synchroniser, the request comes from another master
  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      hold_s1_ff <= 1'b0;
      hold_s2_ff <= 1'b0;
    end
    else if (ce_in)
    begin
      hold_s1_ff <= bus_request_in;
      hold_s2_ff <= hold_s1_ff;
    end
  end

  // Ready sampled at the end of phase 1 of every command state
  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      ready_seen_ff <= 1'b0;
    else if (p1_end)
      ready_seen_ff <= in_tc & ~ready_n_in;
  end

  // Current operation and split progress
  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      op_ff <= '{op: CLB_OP_MEM_RD, is_word: 1'b0, addr: CLB_ADDR_RST, wdata: CLB_DATA_RST};
      step2_ff <= 1'b0;
    end
    else if (load_piece)
    begin
      if (take)
        op_ff <= '{op: req_in.op, is_word: req_in.is_word, addr: req_addr_m, wdata: req_in.wdata};
      step2_ff <= ~take;
    end
  end

  // Address mode kept per operation, so a mode change while an operation
  // is in flight cannot move the second half of a split word
  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      real_ff <= 1'b0;
    else if (take)
      real_ff <= real_mode_in;
  end

  // Address pins change only at the end of a processor clock, so the old
  // address stays through phase 1 of the first command state
  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      addr_ff <= CLB_ADDR_RST;
      ube_n_ff <= 1'b1;
    end
    else if (load_piece)
    begin
      addr_ff <= {ld_addr[23:1], lane_ld.addr_lsb};
      ube_n_ff <= lane_ld.ube_n;
    end
  end

  // Status lines active for the status state only
  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      status_ff <= CLB_STAT_IDLE;
    else if (pclk_end)
      status_ff <= (nxt_state == CLB_ST_STATUS) ? ld_status : CLB_STAT_IDLE;
  end

  // Output enables and hold acknowledge
  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      addr_oe_ff <= 1'b1;
      grant_ff <= 1'b0;
    end
    else if (pclk_end)
    begin
      addr_oe_ff <= (nxt_state != CLB_ST_HOLD);
      grant_ff <= (nxt_state == CLB_ST_HOLD);
    end
  end

  // Write data: driven from phase 2 of the status state, kept one system
  // clock past the last command state, kept on for back to back writes
  wire data_start = p1_end & in_ts & cur_write;
  wire data_stop = p1_end & ~in_ts & ~in_tc;

  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      data_ff <= CLB_DATA_RST;
      data_oe_ff <= 1'b0;
    end
    else if (data_start)
    begin
      data_ff <= lane_cur.wbus;
      data_oe_ff <= 1'b1;
    end
    else if (data_stop | (p1_end & in_ts))
      data_oe_ff <= 1'b0;
  end

  // Read data merge and completion pulse
  wire rd_capture = pclk_end & piece_done & cur_read;

  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      rdata_ff <= CLB_DATA_RST;
    else if (rd_capture)
    begin
      if (lane_cur.take_lo)
        rdata_ff[7:0] <= lane_cur.rd_lo;
      if (lane_cur.take_hi)
        rdata_ff[15:8] <= lane_cur.rd_hi;
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      rsp_valid_ff <= 1'b0;
    else if (ce_in)
      rsp_valid_ff <= pclk_end & op_done;
  end

  // Pin drive
  assign addr_out = addr_ff[23:1];
  assign address_lsb_out = addr_ff[0];
  assign upper_byte_enable_n_out = ube_n_ff;
  assign mem_io_out = status_ff[3];
  assign code_inta_out = status_ff[2];
  assign status_line_1_out = status_ff[1];
  assign status_line_0_out = status_ff[0];
  assign addr_oe_out = addr_oe_ff;
  assign bus_grant_ack_out = grant_ff;
  assign data_out = data_ff;
  assign data_oe_out = data_oe_ff;
  assign rsp_valid_out = rsp_valid_ff;
  assign rsp_rdata_out = rdata_ff;

  // Checks
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!nrst_in);

  AST_LANE_LEGAL: assert property (in_ts |-> !(address_lsb_out && upper_byte_enable_n_out))
    else $error("odd address with upper lane disabled");
  AST_SPLIT_SECOND: assert property (pclk_end && piece_done && need_split |=> in_ts && !address_lsb_out && upper_byte_enable_n_out)
    else $error("second half of odd word not on low lane");
  AST_PHASE_HALVE: assert property (ce_in && (in_ts || in_tc) |=> phase2_ff != $past(phase2_ff))
    else $error("processor clock phase did not alternate");
  AST_TS_THEN_TC: assert property (in_ts && pclk_end |=> in_tc)
    else $error("status state not followed by command state");
  AST_WAIT_STATE: assert property (in_tc && pclk_end && !ready_seen_ff |=> in_tc)
    else $error("command state ended without ready");
  AST_HOLD_FLOAT: assert property (bus_grant_ack_out |-> !addr_oe_out && !data_oe_out && in_th)
    else $error("bus driven during hold");
  AST_STATUS_OFF: assert property (in_tc |-> status_line_1_out && status_line_0_out)
    else $error("status lines active in command state");
  AST_STATUS_ON: assert property (in_ts |-> !(status_line_1_out && status_line_0_out) || op_ff.op == CLB_OP_HALT
    || op_ff.op == CLB_OP_INTA)
    else $error("status state without active status lines");
  AST_ADDR_HOLD: assert property (ce_in && in_ts && phase2_ff |=> $stable(addr_out) && $stable(address_lsb_out))
    else $error("address changed entering command state");
  AST_WDATA_HOLD: assert property (pclk_end && op_done && data_oe_out |=> data_oe_out)
    else $error("write data dropped at end of last command state");
  AST_HOLD_GAP: assert property (pclk_end && op_done && cur_write && hold_req |=> in_ti)
    else $error("no idle state between write and hold");
  AST_REAL_MASK: assert property (in_ts && real_ff && !op_io |-> addr_out[23:20] == 4'h0)
    else $error("real mode address above one megabyte");

endmodule

// [dv/clb_bus_partner.sv]
module clb_bus_partner
  import clb_pkg::*;
(
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic [1:0] max_wait_in,
  input wire logic [3:0] stat_in,
  input wire logic [23:0] addr_in,
  input wire logic ube_n_in,
  input wire logic addr_oe_in,
  input wire logic [15:0] wdata_in,
  input wire logic wdata_oe_in,
  output logic ready_n_out = 1'b1,
  output logic [15:0] rdata_out = 16'h0000,
  output logic phase_next_p1_out = 1'b0,
  output logic piece_out = 1'b0,
  output logic [44:0] info_out,
  output int viol_out = 0
);
  timeunit 1ns;
  timeprecision 100ps;
  logic busy = 1'b0, post = 1'b0, first, ube, rn, pc, xcvr_dir, cmd_dly, cmd_on = 1'b0, cmd_oe;
  logic [1:0] t, w;
  logic [3:0] st;
  logic [23:0] a;
  logic [15:0] wd, rd, cmd_wd;
  integer seed = 32'he601;
  // Transceivers point outward only for writes, whatever the command delay
  assign xcvr_dir = st[1:0] == 2'b10;
  // Byte image of memory and I/O
  function automatic logic [7:0] mb(input logic [23:0] x);
    return x[7:0] ^ x[15:8] ^ 8'h5a;
  endfunction
  // Controller and memory, one step per system clock; idle lines toggle at random
  always @(posedge clk_in)
  begin
    rn = 1'($random(seed));
    rd = 16'($random(seed));
    pc = 1'b0;
    if (post && (wdata_oe_in !== 1'b1 || wdata_in !== wd)) // Write data held past last command
      viol_out++;
    post = 1'b0;
    if (!nrst_in)
      busy = 1'b0;
    else if (!busy && addr_oe_in === 1'b1 && stat_in[1:0] !== 2'b11)
    begin
      if (phase_next_p1_out !== 1'b0) // Status opens in phase 1
        viol_out++;
      busy = 1'b1;
      first = 1'b1;
      t = 2'd0;
      st = stat_in;
      a = addr_in; // Latch keeps the old address until the next status
      ube = ube_n_in;
      w = 2'($unsigned($random(seed)) % (max_wait_in + 3'd1));
    end
    else if (busy)
    begin
      t = t + 2'd1;
      if (t == 2'd1 && xcvr_dir && wdata_oe_in !== 1'b1) // Write data from status phase 2
        viol_out++;
      if (t != 2'd1 && stat_in[1:0] !== 2'b11) // No status during command states
        viol_out++;
      if (t == 2'd2 && first && addr_in !== a) // Address kept in first command phase 1
        viol_out++;
      if (t == 2'd2)
        rd = {mb(a | 24'h1), mb(a & ~24'h1)}; // Even byte low lane, odd byte high lane
      if (t == 2'd3 && w == 2'd0)
      begin
        busy = 1'b0;
        post = xcvr_dir;
        if (xcvr_dir && cmd_on && (cmd_oe !== 1'b1 || cmd_wd !== wdata_in)) // Write data set up before command
          viol_out++;
        wd = wdata_in;
        pc = 1'b1;
        info_out <= #1 {st, ube, a, xcvr_dir ? wdata_in : 16'h0000};
      end
      else if (t == 2'd3)
      begin
        first = 1'b0;
        w = w - 2'd1;
        t = 2'd1;
      end
      if (busy && t == 2'd1) // Ready in phase 1 of a command state is low only in the last one; other phases random
        rn = w != 2'd0;
    end
    piece_out <= #1 pc;
    ready_n_out <= #1 rn;
    rdata_out <= #1 rd;
    phase_next_p1_out <= #1 ~phase_next_p1_out;
  end
  // Command: after status, sampled on each falling edge until the random
  // delay input reads low, then held until the operation ends
  always @(negedge clk_in)
  begin
    cmd_dly = 1'($random(seed));
    if (!busy)
      cmd_on = 1'b0;
    else if (t != 2'd0 && !cmd_on && !cmd_dly)
    begin
      cmd_on = 1'b1;
      cmd_oe = wdata_oe_in;
      cmd_wd = wdata_in;
    end
  end
endmodule

// [dv/clb_bus_unit_tb.sv]
module clb_bus_unit_tb
  import clb_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_in = 1'b0, nrst_in = 1'b0, real_mode = 1'b0, req_valid = 1'b0, bus_req = 1'b0;
  logic req_ready, rsp_valid, data_oe, addr_lsb, ube_n, s1, s0, mem_io, code_inta, addr_oe, grant;
  logic ready_n, ph, piece, g_prev = 1'b0;
  logic [1:0] max_wait = 2'd0;
  logic [15:0] rsp_rdata, data_in, data_out;
  logic [23:1] addr_hi;
  logic [44:0] info, ep, mk;
  logic [17:0] er;
  logic [44:0] exp_p[$];
  logic [17:0] exp_r[$];
  logic [3:0] stc [6] = '{CLB_STAT_MEM_RD, CLB_STAT_MEM_WR, CLB_STAT_IO_RD, CLB_STAT_IO_WR,
    CLB_STAT_INTA, CLB_STAT_HALT};
  clb_req_t req = '0;
  int rc[$];
  int n_errors = 0, total_checks = 0, cyc = 0, p_cyc = 0, g_cyc = 0, viol;
  integer seed = 32'he601;
  // System clock
  always #12.5 clk_in = ~clk_in;
  clb_bus_unit dut (
    .clk_in(clk_in), .nrst_in(nrst_in), .ce_in(1'b1), .real_mode_in(real_mode),
    .req_valid_in(req_valid), .req_ready_out(req_ready), .req_in(req), .rsp_valid_out(rsp_valid),
    .rsp_rdata_out(rsp_rdata), .ready_n_in(ready_n), .bus_request_in(bus_req), .phase_next_p1_in(ph),
    .data_in(data_in), .data_out(data_out), .data_oe_out(data_oe), .addr_out(addr_hi),
    .address_lsb_out(addr_lsb), .upper_byte_enable_n_out(ube_n), .status_line_1_out(s1),
    .status_line_0_out(s0), .mem_io_out(mem_io), .code_inta_out(code_inta), .addr_oe_out(addr_oe),
    .bus_grant_ack_out(grant)
  );
  clb_bus_partner far_end (
    .clk_in(clk_in), .nrst_in(nrst_in), .max_wait_in(max_wait), .stat_in({mem_io, code_inta, s1, s0}),
    .addr_in({addr_hi, addr_lsb}), .ube_n_in(ube_n), .addr_oe_in(addr_oe), .wdata_in(data_out),
    .wdata_oe_in(data_oe), .ready_n_out(ready_n), .rdata_out(data_in), .phase_next_p1_out(ph),
    .piece_out(piece), .info_out(info), .viol_out(viol)
  );
  function automatic logic [7:0] mb(input logic [23:0] x);
    return x[7:0] ^ x[15:8] ^ 8'h5a;
  endfunction
  task automatic check(input string nm, input logic [47:0] seen, input logic [47:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d, errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // Issue one request and note its bus pieces and response
  task automatic issue(input clb_op_t op, input logic wd, input logic [23:0] r, input logic rm);
    logic [23:0] ad, a1, m;
    logic [15:0] w;
    logic [3:0] sc;
    logic wr;
    int n;
    if (op > CLB_OP_IO_WR)
      r = r & CLB_MASK_IO;
    w = 16'($random(seed));
    if (!wd)
      w[15:8] = w[7:0];
    sc = stc[op];
    wr = sc[1:0] == 2'b10;
    m = (op == CLB_OP_IO_RD || op == CLB_OP_IO_WR) ? CLB_MASK_IO : rm ? CLB_MASK_REAL : CLB_MASK_FULL;
    ad = r & m;
    a1 = (r + CLB_ADDR_STEP) & m;
    if (wd && ad[0])
    begin
      exp_p.push_back({sc, 1'b0, ad, wr ? {w[7:0], 8'h00} : 16'h0000});
      exp_p.push_back({sc, 1'b1, a1, wr ? {8'h00, w[15:8]} : 16'h0000});
    end
    else
      exp_p.push_back({sc, ~(wd | ad[0]), ad, wr ? w : 16'h0000});
    exp_r.push_back({op == CLB_OP_MEM_RD || op == CLB_OP_IO_RD || op == CLB_OP_INTA, wd, wd ? mb(a1) : 8'h00, mb(ad)});
    req_valid = 1'b1;
    real_mode = rm;
    req = '{op, wd, r, w};
    n = 0;
    do
    begin
      @(negedge clk_in);
      n++;
    end
    while (req_ready !== 1'b1 && n < 200);
    check("take wait", req_ready, 1'b1);
    @(posedge clk_in);
    #1;
  endtask
  // Let every noted piece and response come back
  task automatic drain();
    int n = 0;
    req_valid = 1'b0;
    while (exp_p.size() + exp_r.size() > 0 && n < 200)
    begin
      @(posedge clk_in);
      n++;
    end
    #1;
  endtask
  // Hold request raised during an operation; gap from its end to grant
  task automatic hold_chk(input clb_op_t op, input int gap);
    int n = 0;
    issue(op, 1'b0, 24'($random(seed)), 1'b0);
    req_valid = 1'b0;
    bus_req = 1'b1;
    while (grant !== 1'b1 && n < 100)
    begin
      @(posedge clk_in);
      n++;
    end
    #1;
    check("hold gap", g_cyc - p_cyc, gap);
    check("floated", {addr_oe, data_oe, grant}, 3'b001);
    bus_req = 1'b0;
    while (grant !== 1'b0 && n < 200)
    begin
      @(posedge clk_in);
      n++;
    end
    #1;
  endtask
  // Main sequence
  initial
  begin
    repeat (20) @(posedge clk_in);
    #1;
    nrst_in = 1'b1;
    for (int i = 0; i < 96; i++)
    begin
      max_wait = 2'(i / 32);
      issue(clb_op_t'(i % 6), i[3], 24'($random(seed)), 1'($random(seed)));
    end
    drain();
    max_wait = 2'd0;
    rc.delete();
    repeat (4) issue(CLB_OP_MEM_RD, 1'b1, 24'($random(seed)) & ~24'h1, 1'b0);
    drain();
    for (int k = 0; k < 3; k++)
      check("spacing", rc[k + 1] - rc[k], 4);
    hold_chk(CLB_OP_MEM_WR, 2);
    hold_chk(CLB_OP_MEM_RD, 0);
    drain();
    check("bus timing", viol, 0);
    check("leftover", exp_p.size() + exp_r.size(), 0);
    wrap_up();
  end
  // Scoreboard on pieces and responses, grant edge capture, hang guard
  always @(posedge clk_in)
  begin
    cyc++;
    if (piece === 1'b1)
    begin
      p_cyc = cyc;
      ep = exp_p.size() > 0 ? exp_p.pop_front() : '1;
      mk = {29'h1fffffff, {8{~info[40]}}, {8{~info[16]}}};
      check("piece", info & mk, ep & mk);
    end
    if (rsp_valid === 1'b1)
    begin
      rc.push_back(cyc);
      er = exp_r.size() > 0 ? exp_r.pop_front() : '1;
      if (er[17])
        check("read data", {rsp_rdata[15:8] & {8{er[16]}}, rsp_rdata[7:0]}, er[15:0]);
    end
    if (grant === 1'b1 && g_prev !== 1'b1)
      g_cyc = cyc;
    g_prev = grant;
    if (cyc == 20000)
    begin
      n_errors++;
      wrap_up();
    end
  end
endmodule
